// *** exec_pkg.sv ***
package exec_pkg;
    // register offsets on the bus (byte addresses)
    localparam logic [7:0] A_CMD   = 8'h00;
    localparam logic [7:0] A_OPND  = 8'h04;
    localparam logic [7:0] A_PC    = 8'h08;
    localparam logic [7:0] A_FLAGS = 8'h0C;
    localparam logic [7:0] A_COUNT = 8'h10;
    localparam logic [7:0] A_SRC   = 8'h14;
    localparam logic [7:0] A_DST   = 8'h18;
    localparam logic [7:0] A_GPR   = 8'h1C;
    localparam logic [7:0] A_STAT  = 8'h20;
    localparam logic [7:0] A_EXC   = 8'h24;

    // instruction codes in the command register
    localparam logic [3:0] OP_BCOND    = 4'h0;
    localparam logic [3:0] OP_JUMP     = 4'h1;
    localparam logic [3:0] OP_CALL_ABS = 4'h2;
    localparam logic [3:0] OP_CALL_REL = 4'h3;
    localparam logic [3:0] OP_RETURN   = 4'h4;
    localparam logic [3:0] OP_EXC_RET  = 4'h5;
    localparam logic [3:0] OP_SLEEP    = 4'h6;
    localparam logic [3:0] OP_LDFLAGS  = 4'h7;
    localparam logic [3:0] OP_STFLAGS  = 4'h8;
    localparam logic [3:0] OP_ANDF     = 4'h9;
    localparam logic [3:0] OP_ORF      = 4'hA;
    localparam logic [3:0] OP_XORF     = 4'hB;
    localparam logic [3:0] OP_NOP      = 4'hC;
    localparam logic [3:0] OP_BLKMOVE  = 4'hD;

    // branch condition codes
    localparam logic [3:0] COND_ALWAYS     = 4'h0;
    localparam logic [3:0] COND_NEVER      = 4'h1;
    localparam logic [3:0] COND_HIGHER     = 4'h2;
    localparam logic [3:0] COND_LOWER_SAME = 4'h3;
    localparam logic [3:0] COND_C_CLR      = 4'h4;
    localparam logic [3:0] COND_C_SET      = 4'h5;
    localparam logic [3:0] COND_Z_CLR      = 4'h6;
    localparam logic [3:0] COND_Z_SET      = 4'h7;
    localparam logic [3:0] COND_V_CLR      = 4'h8;
    localparam logic [3:0] COND_V_SET      = 4'h9;
    localparam logic [3:0] COND_N_CLR      = 4'hA;
    localparam logic [3:0] COND_N_SET      = 4'hB;
    localparam logic [3:0] COND_GE         = 4'hC;
    localparam logic [3:0] COND_LT         = 4'hD;
    localparam logic [3:0] COND_GT         = 4'hE;
    localparam logic [3:0] COND_LE         = 4'hF;

    // flag bit positions, status bits
    localparam int FLG_C     = 0;
    localparam int FLG_V     = 1;
    localparam int FLG_Z     = 2;
    localparam int FLG_N     = 3;
    localparam int ST_BUSY   = 0;
    localparam int ST_SLEEP  = 1;

    // reset values and sizes
    localparam logic [15:0] PC_RST    = 16'h0000;
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [15:0] INSN_STEP = 16'h0002;
    localparam logic [7:0]  COUNT_ONE = 8'h01;
    localparam int          SP_W      = 3;

    // command word layout
    typedef struct packed {
        logic [7:0] rsv_hi;
        logic [7:0] imm;
        logic [2:0] rsv_mid;
        logic       from_reg;
        logic [3:0] cond;
        logic [3:0] rsv_lo;
        logic [3:0] op;
    } cmd_t;

    // byte memory request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

    typedef enum logic [1:0] {MV_IDLE, MV_READ, MV_WAIT, MV_WRITE} mv_state_t;
endpackage

// *** branch_sysctl_blockmove_exec.sv ***
`timescale 1ns/1ns
// Summary of operation
// RULE1 - condition 0000 always, 0001 never, 0010/0011 on C or Z, 0100/0101 on C
// RULE2 - conditions 0110/0111 test Z, 1000/1001 test V, 1010/1011 test N
// RULE3 - conditions 1100/1101 test N xor V, 1110/1111 test Z or (N xor V)
// RULE4 - absolute jump loads the program counter with the operand unconditionally
// RULE5 - absolute call pushes the return point then jumps to the operand
// RULE6 - relative call pushes the return point then jumps by signed displacement
// RULE7 - subroutine return pops the last pushed return point into the program counter
// RULE8 - exception return restores saved program counter and flags and resumes
// RULE9 - power-down instruction stops execution and enters the power-down state
// RULE10 - load-flags writes immediate or general register byte into the flags
// RULE11 - store-flags copies the whole flags byte into the general register
// RULE12 - flags-and replaces flags with flags AND immediate
// RULE13 - flags-or replaces flags with flags OR immediate
// RULE14 - flags-xor replaces flags with flags XOR immediate
// RULE15 - no-operation only advances the program counter by 2
// RULE16 - block move copies bytes, post-increments pointers, counts down; zero moves none
// RULE17 - count from low byte of register 4, source register 5, destination register 6
// RULE18 - next instruction waits for the block move, then starts at once; the code drops a command written while busy
// RULE19 - software keeps destination plus count at or below FFFF, no wrap
// RULE20 - in sleep the core halts, registers kept, other modules keep running
module branch_sysctl_blockmove_exec
    import exec_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // byte memory for block moves
    output logic      [15:0] MEM_ADDR,
    output logic             MEM_RD,
    output logic             MEM_WR,
    output logic      [7:0]  MEM_WDATA,
    input  wire logic [7:0]  MEM_RDATA,
    // power state
    output logic             SLEEPING
);

    logic            rst_meta_q;
    logic            rst_n_q;
    logic            ack_q;
    logic [31:0]     rdat_q;
    logic [15:0]     pc_q;
    logic [7:0]      flags_q;
    logic [15:0]     opnd_q;
    logic [7:0]      count_q;
    logic [15:0]     src_q;
    logic [15:0]     dst_q;
    logic [7:0]      gpr_q;
    logic [23:0]     exc_q;
    logic            sleep_q;
    logic [SP_W-1:0] sp_q;
    logic [15:0]     ret_stack_q [2**SP_W];
    mv_state_t       mv_q;
    mem_req_t        mem_q;
    logic            req;
    logic            wr_fire;
    logic            busy;
    logic            cmd_fire;
    cmd_t            cmd;
    logic [15:0]     next_pc;
    logic [15:0]     rel_pc;
    logic            taken;

    // reset release through two flops
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // branch condition evaluation
    function automatic logic cond_true(input logic [3:0] code, input logic [7:0] f);
        logic c;
        logic v;
        logic z;
        logic n;
        c = f[FLG_C];
        v = f[FLG_V];
        z = f[FLG_Z];
        n = f[FLG_N];
        unique case (code)
            COND_ALWAYS:     cond_true = 1'b1;               // RULE1
            COND_NEVER:      cond_true = 1'b0;               // RULE1
            COND_HIGHER:     cond_true = !(c | z);           // RULE1
            COND_LOWER_SAME: cond_true = c | z;              // RULE1
            COND_C_CLR:      cond_true = !c;                 // RULE1
            COND_C_SET:      cond_true = c;                  // RULE1
            COND_Z_CLR:      cond_true = !z;                 // RULE2
            COND_Z_SET:      cond_true = z;                  // RULE2
            COND_V_CLR:      cond_true = !v;                 // RULE2
            COND_V_SET:      cond_true = v;                  // RULE2
            COND_N_CLR:      cond_true = !n;                 // RULE2
            COND_N_SET:      cond_true = n;                  // RULE2
            COND_GE:         cond_true = !(n ^ v);           // RULE3
            COND_LT:         cond_true = n ^ v;              // RULE3
            COND_GT:         cond_true = !(z | (n ^ v));     // RULE3
            COND_LE:         cond_true = z | (n ^ v);        // RULE3
        endcase
    endfunction

    // byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // bus request decode and instruction launch
    assign req      = WB_CYC_I & WB_STB_I;
    assign wr_fire  = req & WB_WE_I & ack_q;
    assign busy     = (mv_q != MV_IDLE);
    assign cmd      = cmd_t'(WB_DAT_I);
    assign cmd_fire = wr_fire && (WB_ADR_I == A_CMD) && WB_SEL_I[0] && !busy && !sleep_q; // RULE18
    assign next_pc  = pc_q + INSN_STEP;
    assign rel_pc   = next_pc + opnd_q;
    assign taken    = cond_true(cmd.cond, flags_q);

    // wishbone acknowledge, one wait state
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & !ack_q;
        end
    end

    // read data, captured with the acknowledge
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdat_q <= 32'h0000_0000;
        end else if (req && !ack_q) begin
            unique case (WB_ADR_I)
                A_OPND:  rdat_q <= {16'h0000, opnd_q};
                A_PC:    rdat_q <= {16'h0000, pc_q};
                A_FLAGS: rdat_q <= {24'h00_0000, flags_q};
                A_COUNT: rdat_q <= {24'h00_0000, count_q};
                A_SRC:   rdat_q <= {16'h0000, src_q};
                A_DST:   rdat_q <= {16'h0000, dst_q};
                A_GPR:   rdat_q <= {24'h00_0000, gpr_q};
                A_STAT:  rdat_q <= {30'h0000_0000, sleep_q, busy};
                A_EXC:   rdat_q <= {8'h00, exc_q};
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    // operand and exception save registers
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            opnd_q <= 16'h0000;
            exc_q  <= 24'h00_0000;
        end else if (wr_fire) begin
            if (WB_ADR_I == A_OPND) begin
                opnd_q <= merge16(opnd_q, WB_DAT_I, WB_SEL_I);
            end
            if (WB_ADR_I == A_EXC) begin
                exc_q[15:0] <= merge16(exc_q[15:0], WB_DAT_I, WB_SEL_I);
                if (WB_SEL_I[2]) begin
                    exc_q[23:16] <= WB_DAT_I[23:16];
                end
            end
        end
    end

    // program counter
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pc_q <= PC_RST;
        end else if (cmd_fire) begin
            unique case (cmd.op)
                OP_BCOND:    pc_q <= taken ? rel_pc : next_pc;
                OP_JUMP:     pc_q <= opnd_q;                          // RULE4
                OP_CALL_ABS: pc_q <= opnd_q;                          // RULE5
                OP_CALL_REL: pc_q <= rel_pc;                          // RULE6
                OP_RETURN:   pc_q <= ret_stack_q[sp_q - 1'b1];        // RULE7
                OP_EXC_RET:  pc_q <= exc_q[15:0];                     // RULE8
                OP_NOP:      pc_q <= next_pc;                         // RULE15
                default:     pc_q <= next_pc;
            endcase
        end else if (wr_fire && WB_ADR_I == A_PC && !busy) begin
            pc_q <= merge16(pc_q, WB_DAT_I, WB_SEL_I);
        end
    end

    // return stack for subroutine calls
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sp_q <= '0;
        end else if (cmd_fire && (cmd.op == OP_CALL_ABS || cmd.op == OP_CALL_REL)) begin
            sp_q <= sp_q + 1'b1;                                      // RULE5 RULE6
        end else if (cmd_fire && cmd.op == OP_RETURN) begin
            sp_q <= sp_q - 1'b1;                                      // RULE7
        end
    end

    // stack storage, written on calls only
    always_ff @(posedge REF_CLK) begin
        if (cmd_fire && (cmd.op == OP_CALL_ABS || cmd.op == OP_CALL_REL)) begin
            ret_stack_q[sp_q] <= next_pc;                             // RULE5 RULE6
        end
    end

    // flags register
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flags_q <= FLAGS_RST;
        end else if (cmd_fire) begin
            unique case (cmd.op)
                OP_EXC_RET: flags_q <= exc_q[23:16];                  // RULE8
                OP_LDFLAGS: flags_q <= cmd.from_reg ? gpr_q : cmd.imm; // RULE10
                OP_ANDF:    flags_q <= flags_q & cmd.imm;             // RULE12
                OP_ORF:     flags_q <= flags_q | cmd.imm;             // RULE13
                OP_XORF:    flags_q <= flags_q ^ cmd.imm;             // RULE14
                default:    flags_q <= flags_q;
            endcase
        end else if (wr_fire && WB_ADR_I == A_FLAGS && WB_SEL_I[0] && !busy) begin
            flags_q <= WB_DAT_I[7:0];
        end
    end

    // general register used by flag load and store
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gpr_q <= 8'h00;
        end else if (cmd_fire && cmd.op == OP_STFLAGS) begin
            gpr_q <= flags_q;                                         // RULE11
        end else if (wr_fire && WB_ADR_I == A_GPR && WB_SEL_I[0]) begin
            gpr_q <= WB_DAT_I[7:0];
        end
    end

    // power-down state; core halts but registers and bus stay alive
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sleep_q <= 1'b0;
        end else if (cmd_fire && cmd.op == OP_SLEEP) begin
            sleep_q <= 1'b1;                                          // RULE9 RULE20
        end else if (wr_fire && WB_ADR_I == A_STAT && WB_SEL_I[0] && !WB_DAT_I[ST_SLEEP]) begin
            sleep_q <= 1'b0;
        end
    end

    // block move sequencer
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mv_q <= MV_IDLE;
        end else begin
            unique case (mv_q)
                MV_IDLE:  if (cmd_fire && cmd.op == OP_BLKMOVE && count_q != 8'h00) begin
                    mv_q <= MV_READ;                                  // RULE16
                end
                MV_READ:  mv_q <= MV_WAIT;
                MV_WAIT:  mv_q <= MV_WRITE;
                MV_WRITE: mv_q <= (count_q == COUNT_ONE) ? MV_IDLE : MV_READ; // RULE16 RULE18
            endcase
        end
    end

    // block move count and pointers
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            count_q <= 8'h00;
            src_q   <= 16'h0000;
            dst_q   <= 16'h0000;
        end else if (mv_q == MV_WRITE) begin
            count_q <= count_q - COUNT_ONE;                           // RULE16
            src_q   <= src_q + 16'h0001;                              // RULE16
            dst_q   <= dst_q + 16'h0001;                              // RULE16 RULE19
        end else if (wr_fire && !busy) begin
            if (WB_ADR_I == A_COUNT && WB_SEL_I[0]) begin
                count_q <= WB_DAT_I[7:0];                             // RULE17
            end
            if (WB_ADR_I == A_SRC) begin
                src_q <= merge16(src_q, WB_DAT_I, WB_SEL_I);          // RULE17
            end
            if (WB_ADR_I == A_DST) begin
                dst_q <= merge16(dst_q, WB_DAT_I, WB_SEL_I);          // RULE17
            end
        end
    end

    // memory strobes, one cycle each
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mem_q <= '0;
        end else begin
            mem_q.rd <= 1'b0;
            mem_q.wr <= 1'b0;
            if (mv_q == MV_READ) begin
                mem_q.rd   <= 1'b1;
                mem_q.addr <= src_q;                                  // RULE16
            end else if (mv_q == MV_WRITE) begin
                mem_q.wr    <= 1'b1;
                mem_q.addr  <= dst_q;                                 // RULE16
                mem_q.wdata <= MEM_RDATA;
            end
        end
    end

    // outputs
    assign WB_DAT_O  = rdat_q;
    assign WB_ACK_O  = ack_q;
    assign MEM_ADDR  = mem_q.addr;
    assign MEM_RD    = mem_q.rd;
    assign MEM_WR    = mem_q.wr;
    assign MEM_WDATA = mem_q.wdata;
    assign SLEEPING  = sleep_q;

endmodule

// *** branch_sysctl_blockmove_exec_asserts.sv ***
`timescale 1ns/1ns
module branch_sysctl_blockmove_exec_asserts
    import exec_pkg::*;
(
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RESETN,
    // wishbone
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // memory and power
    input wire logic [15:0] MEM_ADDR,
    input wire logic        MEM_RD,
    input wire logic        MEM_WR,
    input wire logic [7:0]  MEM_WDATA,
    input wire logic [7:0]  MEM_RDATA,
    input wire logic        SLEEPING
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    // bus answers one cycle after a fresh request, for one cycle
    a_ack_next: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
        else $error("ack missing after request");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    // each byte read is written back two cycles later with the read data
    a_read_to_write: assert property (
        MEM_RD |-> ##2 (MEM_WR && MEM_WDATA == $past(MEM_RDATA)))
        else $error("block byte not copied");
    a_src_step: assert property (
        (MEM_RD && $past(MEM_RD, 3)) |-> MEM_ADDR == $past(MEM_ADDR, 3) + 16'h0001)
        else $error("source pointer not stepped by one");
    a_dst_step: assert property (
        (MEM_WR && $past(MEM_WR, 3)) |-> MEM_ADDR == $past(MEM_ADDR, 3) + 16'h0001)
        else $error("destination pointer not stepped by one");
    a_write_pulse: assert property (MEM_WR |=> !MEM_WR)
        else $error("write strobe longer than one cycle");
    // halted core makes no memory traffic and stays halted until woken
    a_sleep_quiet: assert property (SLEEPING |-> !MEM_RD && !MEM_WR)
        else $error("memory traffic while sleeping");
    a_sleep_holds: assert property (
        (SLEEPING && !(WB_ACK_O && WB_WE_I && WB_ADR_I == A_STAT)) |=> SLEEPING)
        else $error("sleep left without status write");
endmodule

bind branch_sysctl_blockmove_exec branch_sysctl_blockmove_exec_asserts u_asserts (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .SLEEPING(SLEEPING));

// *** branch_sysctl_blockmove_exec_bench.sv ***
`timescale 1ns/1ns
module branch_sysctl_blockmove_exec_bench;
    import exec_pkg::*;
    typedef struct packed {
        logic [3:0] op;
        logic       frm;
        logic [7:0] imm, fin, gin, fexp, gexp;
    } row_t;
    // flag instructions: inputs beside expected flags and general register
    localparam row_t ROWS [7] = '{
        '{OP_LDFLAGS, 1'b0, 8'hA5, 8'h00, 8'h11, 8'hA5, 8'h11},
        '{OP_LDFLAGS, 1'b1, 8'h00, 8'h00, 8'h3C, 8'h3C, 8'h3C},
        '{OP_STFLAGS, 1'b0, 8'h00, 8'h96, 8'h00, 8'h96, 8'h96},
        '{OP_ANDF, 1'b0, 8'h3C, 8'hF0, 8'h00, 8'h30, 8'h00},
        '{OP_ORF, 1'b0, 8'h30, 8'h0F, 8'h00, 8'h3F, 8'h00},
        '{OP_XORF, 1'b0, 8'h5A, 8'hFF, 8'h00, 8'hA5, 8'h00},
        '{OP_NOP, 1'b0, 8'hFF, 8'h77, 8'h42, 8'h77, 8'h42}};
    logic        clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat, d;
    logic        ack, mem_rd, mem_wr, sleeping;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata, mem_rdata = 8'h00;
    logic [7:0]  mem [0:65535];
    logic [31:0] rd_count = 32'h0000_0000;
    int          miscompares = 0, num_checks = 0;

    branch_sysctl_blockmove_exec uut (.REF_CLK(clk), .RESETN(resetn), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
        .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .SLEEPING(sleeping));

    always #5 clk = ~clk;
    // byte memory: data one cycle after the read strobe, garbage otherwise
    always @(posedge clk) begin
        if (mem_wr) mem[mem_addr] <= mem_wdata;
        mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
        if (mem_rd) rd_count <= rd_count + 1;
    end
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h5A;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        sel <= s;
        @(posedge clk);
        // the acknowledge ends the wait; only the watchdog ends a wait that never sees one
        while (ack !== 1'b1) @(posedge clk);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0000_0000, 4'hF);
        check(what, d, exp);
    endtask
    task automatic run_cmd(input logic [3:0] op, input logic [3:0] code, input logic frm,
                           input logic [7:0] imm);
        cmd_t c;
        c = '0;
        c.op = op;
        c.cond = code;
        c.from_reg = frm;
        c.imm = imm;
        wb(1'b1, A_CMD, c, 4'hF);
    endtask
    function automatic logic taken(input logic [3:0] code, input logic [3:0] f);
        logic e;
        case (code[3:1])
            3'd0: e = 1'b0;
            3'd1: e = f[FLG_C] | f[FLG_Z];
            3'd2: e = f[FLG_C];
            3'd3: e = f[FLG_Z];
            3'd4: e = f[FLG_V];
            3'd5: e = f[FLG_N];
            3'd6: e = f[FLG_N] ^ f[FLG_V];
            default: e = f[FLG_Z] | (f[FLG_N] ^ f[FLG_V]);
        endcase
        return e == code[0];
    endfunction
    task automatic finish_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk_reg(A_PC, 32'h0000_0000, "pc reset");
        chk_reg(A_FLAGS, 32'h0000_0000, "flags reset");
        chk_reg(A_STAT, 32'h0000_0000, "status reset");
        wb(1'b1, 8'h30, 32'hFFFF_FFFF, 4'hF);
        chk_reg(8'h30, 32'h0000_0000, "unmapped");
        // table of flag instructions
        foreach (ROWS[i]) begin
            wb(1'b1, A_PC, 32'h0000_0100, 4'hF);
            wb(1'b1, A_FLAGS, {24'h0, ROWS[i].fin}, 4'hF);
            wb(1'b1, A_GPR, {24'h0, ROWS[i].gin}, 4'hF);
            run_cmd(ROWS[i].op, 4'h0, ROWS[i].frm, ROWS[i].imm);
            chk_reg(A_FLAGS, {24'h0, ROWS[i].fexp}, "flags");
            chk_reg(A_GPR, {24'h0, ROWS[i].gexp}, "gpr");
            chk_reg(A_PC, 32'h0000_0102, "pc step");
        end
        // every condition code against every flag pattern, backward displacement
        wb(1'b1, A_OPND, 32'h0000_FFF0, 4'hF);
        for (int c = 0; c < 16; c++) begin
            for (int f = 0; f < 16; f++) begin
                wb(1'b1, A_FLAGS, 32'(f), 4'hF);
                wb(1'b1, A_PC, 32'h0000_1000, 4'hF);
                run_cmd(OP_BCOND, 4'(c), 1'b0, 8'h00);
                chk_reg(A_PC, taken(4'(c), 4'(f)) ? 32'h0000_0FF2 : 32'h0000_1002,
                        "branch");
            end
        end
        // jump, nested calls and returns
        wb(1'b1, A_OPND, 32'h0000_1234, 4'hF);
        run_cmd(OP_JUMP, 4'h1, 1'b0, 8'h00);
        chk_reg(A_PC, 32'h0000_1234, "jump");
        wb(1'b1, A_OPND, 32'h0000_2000, 4'hF);
        run_cmd(OP_CALL_ABS, 4'h0, 1'b0, 8'h00);
        chk_reg(A_PC, 32'h0000_2000, "abs call");
        wb(1'b1, A_OPND, 32'h0000_0100, 4'hF);
        run_cmd(OP_CALL_REL, 4'h0, 1'b0, 8'h00);
        chk_reg(A_PC, 32'h0000_2102, "rel call");
        run_cmd(OP_RETURN, 4'h0, 1'b0, 8'h00);
        chk_reg(A_PC, 32'h0000_2002, "inner return");
        run_cmd(OP_RETURN, 4'h0, 1'b0, 8'h00);
        chk_reg(A_PC, 32'h0000_1236, "outer return");
        // exception return restores pc and flags
        wb(1'b1, A_EXC, 32'h00C3_4444, 4'hF);
        run_cmd(OP_EXC_RET, 4'h0, 1'b0, 8'h00);
        chk_reg(A_PC, 32'h0000_4444, "exc pc");
        chk_reg(A_FLAGS, 32'h0000_00C3, "exc flags");
        // sleep: commands ignored, state kept, woken by status write
        run_cmd(OP_SLEEP, 4'h0, 1'b0, 8'h00);
        chk_reg(A_STAT, 32'h0000_0002, "sleep status");
        check("sleeping", {31'h0, sleeping}, 32'h0000_0001);
        run_cmd(OP_NOP, 4'h0, 1'b0, 8'h00);
        chk_reg(A_PC, 32'h0000_4446, "sleep pc");
        chk_reg(A_FLAGS, 32'h0000_00C3, "sleep flags");
        wb(1'b1, A_STAT, 32'h0000_0000, 4'h1);
        // the wake write lands at the ack edge, so look one edge later
        @(posedge clk);
        check("awake", {31'h0, sleeping}, 32'h0000_0000);
        // block move of three bytes, command issued while busy is dropped
        wb(1'b1, A_COUNT, 32'h0000_0003, 4'hF);
        wb(1'b1, A_SRC, 32'h0000_0100, 4'hF);
        wb(1'b1, A_DST, 32'h0000_0200, 4'hF);
        run_cmd(OP_BLKMOVE, 4'h0, 1'b0, 8'h00);
        run_cmd(OP_NOP, 4'h0, 1'b0, 8'h00);
        for (int n = 0; n < 40; n++) begin
            wb(1'b0, A_STAT, 32'h0000_0000, 4'hF);
            if (d[ST_BUSY] !== 1'b1) break;
        end
        check("busy", d, 32'h0000_0000);
        chk_reg(A_PC, 32'h0000_4448, "move pc");
        for (int k = 0; k < 3; k++)
            check("copied", {24'h0, mem[16'h0200 + k]}, {24'h0, 8'(k) ^ 8'h5A});
        check("reads", rd_count, 32'h0000_0003);
        chk_reg(A_COUNT, 32'h0000_0000, "count");
        chk_reg(A_SRC, 32'h0000_0103, "src");
        chk_reg(A_DST, 32'h0000_0203, "dst");
        // zero count moves nothing, next command starts at once
        run_cmd(OP_BLKMOVE, 4'h0, 1'b0, 8'h00);
        run_cmd(OP_NOP, 4'h0, 1'b0, 8'h00);
        chk_reg(A_PC, 32'h0000_444C, "zero move pc");
        check("no reads", rd_count, 32'h0000_0003);
        // mid-run reset returns the core to its reset state
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk_reg(A_PC, 32'h0000_0000, "pc after reset");
        chk_reg(A_SRC, 32'h0000_0000, "src after reset");
        finish_test();
    end
endmodule
